// *** pkg/pcgmo_pkg.sv ***
// Register map, field layout and timing constants of the clock gate block
package pcgmo_pkg;
  // Register byte offsets
  localparam logic [11:0] PCGMO_OFF_PCEN = 12'h010;
  localparam logic [11:0] PCGMO_OFF_PCDIS = 12'h014;
  localparam logic [11:0] PCGMO_OFF_PCSTAT = 12'h018;
  localparam logic [11:0] PCGMO_OFF_MOCTL = 12'h020;
  localparam logic [11:0] PCGMO_OFF_MFREQ = 12'h024;
  localparam logic [11:0] PCGMO_OFF_ISTAT = 12'h068;
  localparam logic [11:0] PCGMO_OFF_IMASK = 12'h06c;
  // Oscillator control fields
  localparam int PCGMO_MOEN_BIT = 0;
  localparam int PCGMO_BYP_BIT = 1;
  localparam int PCGMO_CNT_LSB = 8;
  localparam int PCGMO_CNT_W = 8;
  localparam int PCGMO_CNT_MUL_SHIFT = 3;
  // Frequency register fields
  localparam int PCGMO_FREQ_W = 16;
  localparam int PCGMO_VALID_BIT = 16;
  localparam int PCGMO_WIN_SLOW = 16;
  // Interrupt status bits
  localparam int PCGMO_IRQ_STABLE = 0;
  localparam int PCGMO_IRQ_FREQ = 1;
  localparam int PCGMO_IRQ_W = 2;
  // Peripheral bits below this position are unused
  localparam int PCGMO_PID_LO = 2;
  // Reset values
  localparam logic [31:0] PCGMO_RST_PCSTAT = 32'h0000_0000;
  localparam logic [31:0] PCGMO_RST_MOCTL = 32'h0000_0000;
  localparam logic [31:0] PCGMO_IMPL_DEFAULT = 32'hffff_fffc;
endpackage

// *** logic/pcgmo_sync3.sv ***
// Three-stage synchroniser with agreement filter
`timescale 1ns/100ps
module pcgmo_sync3 (
  input wire logic i_clk,   // Block clock
  input wire logic i_rst_n, // Async reset, active low
  input wire logic i_d,     // Asynchronous input
  output logic o_q          // Filtered level
);
  logic s1;
  logic s2;
  logic s3;
  logic next_q;

  // Level changes only once stages two and three agree
  always_comb begin
    next_q = o_q;
    if (s2 == s3) begin
      next_q = s3;
    end
  end

  // Stage one is read by stage two alone
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
      o_q <= 1'b0;
    end else begin
      s1 <= i_d;
      s2 <= s1;
      s3 <= s2;
      o_q <= next_q;
    end
  end
endmodule

// *** logic/pcgmo_top.sv ***
// Peripheral clock gating and main oscillator control with APB registers
//
// Chosen here: the APB slave port and the register offsets.
`timescale 1ns/100ps
// How it works
// - Writing one to an enable bit turns that peripheral clock on; zeros ignored.
// - Writing one to a disable bit turns that peripheral clock off; zeros ignored.
// - Status bit reads one while its peripheral clock runs, zero while gated.
// - Only bits 2 to 31 carry peripheral clocks; bits 0 and 1 do nothing.
// - Bits for unimplemented peripherals change no behaviour.
// - Oscillator runs while enable is one; software keeps bypass zero then.
// - With bypass zero, the stable flag rises only after the programmed start-up time elapses.
// - Bypass selects the external clock on the crystal input; enable kept zero.
// - Setting bypass sets the stable flag at once.
// - Clearing both enable and bypass clears the stable flag.
// - Start-up delay is the count field times 8 slow-clock cycles.
// - Frequency field counts main-clock cycles in 16 slow-clock periods.
// - Valid bit reads one only when enable or bypass is set and a result is available.
module pcgmo_top import pcgmo_pkg::*; #(
  parameter logic [31:0] IMPL_MASK = PCGMO_IMPL_DEFAULT // Implemented peripheral bits
) (
  input wire logic i_clk,           // Master clock, 50 MHz
  input wire logic i_rst_n,         // Async reset, active low
  input wire logic i_psel,          // APB select
  input wire logic i_penable,       // APB access phase
  input wire logic i_pwrite,        // APB write
  input wire logic [11:0] i_paddr,  // APB byte address
  input wire logic [31:0] i_pwdata, // APB write data
  output logic [31:0] o_prdata,     // APB read data
  output logic o_pready,            // APB ready
  output logic o_pslverr,           // APB error on unmapped address
  input wire logic i_slow_clk,      // Slow clock, sampled as a level
  input wire logic i_main_clk,      // Main clock, sampled as a level
  output logic [31:0] o_periph_clk_en, // Per-peripheral clock gate enables
  output logic o_main_osc_enable,   // Oscillator run control
  output logic o_osc_bypass_a,      // Bypass, external clock on crystal input
  output logic o_main_osc_stable_flag, // Oscillator stable
  output logic o_irq                // Level interrupt
);
  // Bits 0 and 1 carry no peripheral, so a mask that sets them is refused
  if (IMPL_MASK[1:0] != 2'b00) begin : g_mask_chk
    $error("IMPL_MASK bits 0 and 1 must be zero");
  end

  typedef enum logic [1:0] {
    PCGMO_OFF = 2'b00,
    PCGMO_START = 2'b01,
    PCGMO_STABLE = 2'b10
  } pcgmo_osc_t;

  logic [31:0] pclk;
  logic [31:0] next_pclk;
  logic [31:0] moctl;
  logic [31:0] next_moctl;
  logic [PCGMO_IRQ_W-1:0] istat;
  logic [PCGMO_IRQ_W-1:0] next_istat;
  logic [PCGMO_IRQ_W-1:0] imask;
  logic [PCGMO_IRQ_W-1:0] next_imask;
  pcgmo_osc_t ost;
  pcgmo_osc_t next_ost;
  logic [PCGMO_CNT_W+PCGMO_CNT_MUL_SHIFT-1:0] tmr;
  logic [PCGMO_CNT_W+PCGMO_CNT_MUL_SHIFT-1:0] next_tmr;
  logic en_d;
  logic slow_s;
  logic slow_d;
  logic main_s;
  logic main_d;
  logic [4:0] win;
  logic [4:0] next_win;
  logic [PCGMO_FREQ_W-1:0] acc;
  logic [PCGMO_FREQ_W-1:0] next_acc;
  logic [PCGMO_FREQ_W-1:0] freq;
  logic [PCGMO_FREQ_W-1:0] next_freq;
  logic fvalid;
  logic next_fvalid;
  logic wr;
  logic rd_ok;
  logic slow_tick;
  logic main_tick;
  logic en_rise;
  logic stable_set;
  logic freq_set;
  logic [31:0] rd_mux;
  logic [31:0] prdata;
  logic [31:0] next_prdata;
  // Window counter parks here while stopped and waits for a slow edge to start
  localparam logic [4:0] WIN_IDLE = 5'(PCGMO_WIN_SLOW);

  // Asynchronous clocks enter through the three-stage filters
  pcgmo_sync3 u_sync_slow (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_d(i_slow_clk),
    .o_q(slow_s)
  );
  pcgmo_sync3 u_sync_main (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_d(i_main_clk),
    .o_q(main_s)
  );

  // Bus strobes; every access finishes in its first access cycle
  assign wr = i_psel && i_penable && i_pwrite;
  assign o_pready = 1'b1;
  assign slow_tick = slow_s && !slow_d;
  assign main_tick = main_s && !main_d;
  assign en_rise = moctl[PCGMO_MOEN_BIT] && !en_d;

  // Address decode for reads
  always_comb begin
    rd_mux = 32'h0000_0000;
    rd_ok = 1'b1;
    if (i_paddr == PCGMO_OFF_PCEN || i_paddr == PCGMO_OFF_PCDIS) begin
      rd_mux = 32'h0000_0000;
    end else if (i_paddr == PCGMO_OFF_PCSTAT) begin
      rd_mux = pclk;
    end else if (i_paddr == PCGMO_OFF_MOCTL) begin
      rd_mux = moctl;
    end else if (i_paddr == PCGMO_OFF_MFREQ) begin
      rd_mux[PCGMO_FREQ_W-1:0] = freq;
      rd_mux[PCGMO_VALID_BIT] = fvalid;
    end else if (i_paddr == PCGMO_OFF_ISTAT) begin
      rd_mux[PCGMO_IRQ_W-1:0] = istat;
    end else if (i_paddr == PCGMO_OFF_IMASK) begin
      rd_mux[PCGMO_IRQ_W-1:0] = imask;
    end else begin
      rd_ok = 1'b0;
    end
  end
  assign o_pslverr = i_psel && i_penable && !rd_ok;

  // Read data captured in the setup cycle, so the access phase still needs no wait
  always_comb begin
    next_prdata = prdata;
    if (i_psel && !i_penable) begin
      next_prdata = rd_mux;
    end
  end

  // Peripheral gates, control and interrupt registers
  always_comb begin
    next_pclk = pclk;
    next_moctl = moctl;
    next_imask = imask;
    next_istat = istat;
    if (wr && i_paddr == PCGMO_OFF_PCEN) begin
      next_pclk = pclk | (i_pwdata & IMPL_MASK);
    end else if (wr && i_paddr == PCGMO_OFF_PCDIS) begin
      next_pclk = pclk & ~(i_pwdata & IMPL_MASK);
    end else if (wr && i_paddr == PCGMO_OFF_MOCTL) begin
      next_moctl = 32'h0000_0000;
      next_moctl[PCGMO_MOEN_BIT] = i_pwdata[PCGMO_MOEN_BIT];
      next_moctl[PCGMO_BYP_BIT] = i_pwdata[PCGMO_BYP_BIT];
      next_moctl[PCGMO_CNT_LSB +: PCGMO_CNT_W] = i_pwdata[PCGMO_CNT_LSB +: PCGMO_CNT_W];
    end else if (wr && i_paddr == PCGMO_OFF_IMASK) begin
      next_imask = i_pwdata[PCGMO_IRQ_W-1:0];
    end
    // Write one clears, but a new event in the same cycle wins
    if (wr && i_paddr == PCGMO_OFF_ISTAT) begin
      next_istat = istat & ~i_pwdata[PCGMO_IRQ_W-1:0];
    end
    next_istat[PCGMO_IRQ_STABLE] = next_istat[PCGMO_IRQ_STABLE] | stable_set;
    next_istat[PCGMO_IRQ_FREQ] = next_istat[PCGMO_IRQ_FREQ] | freq_set;
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pclk <= PCGMO_RST_PCSTAT;
      prdata <= 32'h0000_0000;
      moctl <= PCGMO_RST_MOCTL;
      imask <= '0;
      istat <= '0;
    end else begin
      pclk <= next_pclk;
      prdata <= next_prdata;
      moctl <= next_moctl;
      imask <= next_imask;
      istat <= next_istat;
    end
  end

  // Oscillator start-up sequence; bypass has priority as it needs no wait
  always_comb begin
    next_ost = ost;
    next_tmr = tmr;
    stable_set = 1'b0;
    case (ost)
      PCGMO_OFF: begin
        if (moctl[PCGMO_BYP_BIT]) begin
          next_ost = PCGMO_STABLE;
          stable_set = 1'b1;
        end else if (en_rise) begin
          next_tmr = {moctl[PCGMO_CNT_LSB +: PCGMO_CNT_W], 3'b000};
          next_ost = PCGMO_START;
        end
      end
      PCGMO_START: begin
        if (moctl[PCGMO_BYP_BIT]) begin
          next_ost = PCGMO_STABLE;
          stable_set = 1'b1;
        end else if (!moctl[PCGMO_MOEN_BIT]) begin
          next_ost = PCGMO_OFF;
        end else if (slow_tick && tmr == '0) begin
          // Zero acts only at a tick, so whole periods lie between first and last tick
          next_ost = PCGMO_STABLE;
          stable_set = 1'b1;
        end else if (slow_tick) begin
          next_tmr = tmr - 1'b1;
        end
      end
      PCGMO_STABLE: begin
        if (!moctl[PCGMO_BYP_BIT] && !moctl[PCGMO_MOEN_BIT]) begin
          next_ost = PCGMO_OFF;
        end
      end
      default: begin
        next_ost = PCGMO_OFF;
      end
    endcase
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ost <= PCGMO_OFF;
      tmr <= '0;
      en_d <= 1'b0;
      slow_d <= 1'b0;
      main_d <= 1'b0;
    end else begin
      ost <= next_ost;
      tmr <= next_tmr;
      en_d <= moctl[PCGMO_MOEN_BIT];
      slow_d <= slow_s;
      main_d <= main_s;
    end
  end

  // Frequency window; filtered sampling limits main clock to under 12.5 MHz
  always_comb begin
    next_win = win;
    next_acc = acc;
    next_freq = freq;
    next_fvalid = fvalid;
    freq_set = 1'b0;
    if (!moctl[PCGMO_MOEN_BIT] && !moctl[PCGMO_BYP_BIT]) begin
      next_win = WIN_IDLE;
      next_acc = '0;
      next_fvalid = 1'b0;
    end else begin
      if (main_tick && acc != '1 && win != WIN_IDLE) begin
        next_acc = acc + 1'b1;
      end
      if (slow_tick) begin
        if (win == WIN_IDLE) begin
          // Window opens on a slow edge so that it spans whole periods
          next_win = '0;
          next_acc = '0;
        end else if (win == 5'(PCGMO_WIN_SLOW - 1)) begin
          next_win = '0;
          next_freq = next_acc;
          next_acc = '0;
          next_fvalid = 1'b1;
          freq_set = !fvalid;
        end else begin
          next_win = win + 1'b1;
        end
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      win <= WIN_IDLE;
      acc <= '0;
      freq <= '0;
      fvalid <= 1'b0;
    end else begin
      win <= next_win;
      acc <= next_acc;
      freq <= next_freq;
      fvalid <= next_fvalid;
    end
  end

  // Outputs
  assign o_prdata = prdata;
  assign o_periph_clk_en = pclk;
  assign o_main_osc_enable = moctl[PCGMO_MOEN_BIT];
  assign o_osc_bypass_a = moctl[PCGMO_BYP_BIT];
  assign o_main_osc_stable_flag = (ost == PCGMO_STABLE);
  assign o_irq = |(istat & imask);
endmodule

// *** verification/pcgmo_checker.sv ***
// Concurrent checks on the clock gate block ports
`timescale 1ns/100ps
module pcgmo_checker import pcgmo_pkg::*; #(
  parameter logic [31:0] IMPL_MASK = PCGMO_IMPL_DEFAULT
) (
  input wire logic i_clk, // Clock
  input wire logic i_rst_n, // Reset
  input wire logic i_psel, // Select
  input wire logic i_penable, // Access
  input wire logic i_pwrite, // Write
  input wire logic [11:0] i_paddr, // Address
  input wire logic [31:0] i_pwdata, // Write data
  input wire logic [31:0] o_prdata, // Read data
  input wire logic [31:0] o_periph_clk_en, // Gates
  input wire logic o_main_osc_enable, // Osc on
  input wire logic o_osc_bypass_a, // Bypass
  input wire logic o_main_osc_stable_flag // Stable
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  // Completed access to one register
  sequence acc(logic [11:0] a, logic w);
    i_psel && i_penable && i_pwrite == w && i_paddr == a;
  endsequence
  en_set_a: assert property (acc(PCGMO_OFF_PCEN, 1'b1) |=>
    (o_periph_clk_en & $past(i_pwdata) & IMPL_MASK) == ($past(i_pwdata) & IMPL_MASK))
    else $error("enable write lost");
  dis_clr_a: assert property (acc(PCGMO_OFF_PCDIS, 1'b1) |=>
    (o_periph_clk_en & $past(i_pwdata)) == 32'h0) else $error("disable write lost");
  stat_rd_a: assert property (acc(PCGMO_OFF_PCSTAT, 1'b0) |->
    o_prdata == o_periph_clk_en) else $error("status read wrong");
  low_bits_a: assert property ((o_periph_clk_en & ~IMPL_MASK) == 32'h0)
    else $error("unused gate set");
  ctl_upd_a: assert property (acc(PCGMO_OFF_MOCTL, 1'b1) |=>
    o_main_osc_enable == $past(i_pwdata[0]) && o_osc_bypass_a == $past(i_pwdata[1]))
    else $error("control bits wrong");
  early_a: assert property (acc(PCGMO_OFF_MOCTL, 1'b1) ##0 i_pwdata[1:0] == 2'h1 &&
    i_pwdata[15:8] != 8'h0 && !o_main_osc_enable && !o_main_osc_stable_flag
    |=> !o_main_osc_stable_flag [*8]) else $error("stable too early");
  byp_set_a: assert property (acc(PCGMO_OFF_MOCTL, 1'b1) ##0 i_pwdata[1]
    |-> ##[1:3] o_main_osc_stable_flag) else $error("bypass not stable");
  stable_clr_a: assert property (acc(PCGMO_OFF_MOCTL, 1'b1) ##0 i_pwdata[1:0] == 2'h0
    |-> ##[1:3] !o_main_osc_stable_flag) else $error("stable not cleared");
  valid_off_a: assert property (acc(PCGMO_OFF_MFREQ, 1'b0) ##0
    !(o_main_osc_enable || o_osc_bypass_a) && $past(!(o_main_osc_enable || o_osc_bypass_a))
    && $past(!(o_main_osc_enable || o_osc_bypass_a), 2)
    |-> !o_prdata[PCGMO_VALID_BIT]) else $error("valid while off");
endmodule
bind pcgmo_top pcgmo_checker #(.IMPL_MASK(IMPL_MASK)) u_chk (.i_clk(i_clk),
  .i_rst_n(i_rst_n), .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite),
  .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
  .o_periph_clk_en(o_periph_clk_en), .o_main_osc_enable(o_main_osc_enable),
  .o_osc_bypass_a(o_osc_bypass_a), .o_main_osc_stable_flag(o_main_osc_stable_flag));

// *** verification/pcgmo_top_tb.sv ***
// Self-checking bench for the clock gate block
`timescale 1ns/100ps
module pcgmo_top_tb import pcgmo_pkg::*; ;
  logic i_clk, i_rst_n, i_psel, i_penable, i_pwrite, i_slow_clk, i_main_clk, er;
  logic [11:0] i_paddr;
  logic [31:0] i_pwdata, o_prdata, o_periph_clk_en, rd;
  logic o_pready, o_pslverr, o_main_osc_enable, o_osc_bypass_a, o_main_osc_stable_flag, o_irq;
  logic [4:0] sc;
  logic [1:0] mc;
  logic [15:0] fq;
  int n_errors, comparisons;
  pcgmo_top dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_psel(i_psel), .i_penable(i_penable),
    .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
    .o_pready(o_pready), .o_pslverr(o_pslverr), .i_slow_clk(i_slow_clk),
    .i_main_clk(i_main_clk), .o_periph_clk_en(o_periph_clk_en),
    .o_main_osc_enable(o_main_osc_enable), .o_osc_bypass_a(o_osc_bypass_a),
    .o_main_osc_stable_flag(o_main_osc_stable_flag), .o_irq(o_irq));
  // Master clock, 20 ns
  initial begin
    i_clk = 1'h0;
    forever #10 i_clk = ~i_clk;
  end
  // Slow clock of 32 cycles; main clock of 6 cycles, held low while the oscillator is off
  always @(posedge i_clk) begin
    sc <= sc + 5'h1;
    i_slow_clk <= sc[4];
    mc <= (mc == 2'h2) ? 2'h0 : mc + 2'h1;
    if (mc == 2'h2) begin
      i_main_clk <= (o_main_osc_enable | o_osc_bypass_a) & ~i_main_clk;
    end
  end
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // One APB transfer; answer taken at the ready edge, released only after it
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    logic rdy;
    i_psel <= 1'h1;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_clk);
    i_penable <= 1'h1;
    rdy = 1'h0;
    while (rdy !== 1'h1) begin
      @(posedge i_clk);
      rd = o_prdata;
      er = o_pslverr;
      rdy = o_pready;
    end
    i_psel <= 1'h0;
    i_penable <= 1'h0;
    @(posedge i_clk);
  endtask
  task automatic rdc(input string what, input logic [11:0] a, input logic [31:0] e);
    apb(1'h0, a, 32'h0);
    check(what, rd, e);
  endtask
  task automatic test_done;
    $display("comparisons %0d n_errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // Watchdog, about 28 times the expected run
  initial begin
    #400000;
    n_errors++;
    test_done();
  end
  initial begin
    {i_rst_n, i_psel, i_penable, i_pwrite, i_slow_clk, i_main_clk, sc, mc} = '0;
    i_paddr = 12'h0;
    i_pwdata = 32'h0;
    repeat (16) @(posedge i_clk);
    i_rst_n <= 1'h1;
    @(posedge i_clk);
    rdc("gate status", PCGMO_OFF_PCSTAT, PCGMO_RST_PCSTAT);
    rdc("osc control", PCGMO_OFF_MOCTL, PCGMO_RST_MOCTL);
    rdc("frequency", PCGMO_OFF_MFREQ, 32'h0);
    $display("reset test done");
    // Gating: bits 0 and 1 never take effect, zeros leave gates alone
    apb(1'h1, PCGMO_OFF_PCEN, 32'hffff_ffff);
    rdc("gate status", PCGMO_OFF_PCSTAT, 32'hffff_fffc);
    apb(1'h1, PCGMO_OFF_PCDIS, 32'h0000_00f3);
    rdc("gate status", PCGMO_OFF_PCSTAT, 32'hffff_ff0c);
    apb(1'h1, PCGMO_OFF_PCEN, 32'h0000_0013);
    check("gates", o_periph_clk_en, 32'hffff_ff1c);
    apb(1'h1, 12'h004, 32'hffff_ffff);
    check("unmapped error", er, 32'h1);
    rdc("gate status", PCGMO_OFF_PCSTAT, 32'hffff_ff1c);
    $display("gating test done");
    // Start-up count 2 means 16 slow cycles, 512 master cycles
    apb(1'h1, PCGMO_OFF_MOCTL, 32'h0000_0201);
    rdc("osc control", PCGMO_OFF_MOCTL, 32'h0000_0201);
    repeat (440) @(posedge i_clk);
    check("stable early", o_main_osc_stable_flag, 32'h0);
    repeat (120) @(posedge i_clk);
    check("stable late", o_main_osc_stable_flag, 32'h1);
    repeat (64) @(posedge i_clk);
    apb(1'h0, PCGMO_OFF_MFREQ, 32'h0);
    check("freq valid", rd[PCGMO_VALID_BIT], 32'h1);
    check("freq count", rd[15:0] >= 16'h54 && rd[15:0] <= 16'h57, 32'h1);
    fq = rd[15:0];
    // Interrupt raised, masked and cleared
    rdc("irq status", PCGMO_OFF_ISTAT, 32'h3);
    apb(1'h1, PCGMO_OFF_IMASK, 32'h2);
    check("irq raised", o_irq, 32'h1);
    apb(1'h1, PCGMO_OFF_IMASK, 32'h0);
    check("irq masked", o_irq, 32'h0);
    apb(1'h1, PCGMO_OFF_IMASK, 32'h2);
    apb(1'h1, PCGMO_OFF_ISTAT, 32'h2);
    check("irq cleared", o_irq, 32'h0);
    $display("oscillator test done");
    // Stop clears stable and the valid bit but keeps the count; bypass sets stable at once
    apb(1'h1, PCGMO_OFF_MOCTL, 32'h0);
    repeat (3) @(posedge i_clk);
    check("stable off", o_main_osc_stable_flag, 32'h0);
    rdc("frequency", PCGMO_OFF_MFREQ, {16'h0, fq});
    apb(1'h1, PCGMO_OFF_MOCTL, 32'h2);
    repeat (3) @(posedge i_clk);
    check("bypass stable", o_main_osc_stable_flag, 32'h1);
    check("bypass out", o_osc_bypass_a, 32'h1);
    $display("bypass test done");
    test_done();
  end
endmodule
